/* File: rtl/bcs_top.sv */
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - system-floor loop flag is status; each change sets a maskable event
// - die over limit cuts current while charging, sets status, change raises event
// - four-bit state code is status; every change sets a maskable event
// - invalid input or disabled charging forces off; invalid input connects battery
// - fresh battery stays off and disconnected until it drops by restart margin
// - below prequal threshold means prequal at reduced rate, threshold selectable
// - prequal lasting thirty minutes since its latest entry ends in prequal fault
// - above prequal threshold move to constant current with selected current
// - reaching regulation voltage moves to constant voltage and holds it
// - current under termination in constant voltage moves to top-off
// - safety timer restarts on entering fast charge from elsewhere, spans it
// - safety length three to seven hours by two-bit field, zero disables
// - safety timer pauses on low current in CC or supplement, status shown
// - safety expiry inside fast charge gives fast-charge fault, no current
// - top-off holds voltage, timer by field, expiry or zero means done
// - done keeps battery disconnected, restarts after restart-margin drop
// - timer faults hold until enable toggled or input removed and returned
// - hot or cold with thermistor on forces temp fault, then resumes state
// - temp fault pauses timers; prequal resumes, safety and top-off restart
// - warm or cool with thermistor on selects alternate current and voltage
// - battery temperature zone reported as three-bit status field
// - alternate voltage and current come from two independent six-bit fields
module bcs_top #(
	parameter int unsigned P_TICK_CYCLES = bcs_pkg::TICK_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	output logic [31:0] o_rd_data,
	input wire bcs_pkg::bcs_ain_t i_analog,
	output bcs_pkg::bcs_drive_t o_drive,
	output logic o_irq
);
	import bcs_pkg::*;

	// ==================================================
	// state
	typedef struct packed {
		bcs_ain_t s1;
		bcs_ain_t s2;
		bcs_phase_t phase;
		bcs_phase_t resume;
		bcs_ctrl_t ctrl;
		bcs_chg_t chg;
		bcs_alt_t alt;
		bcs_tmr_t tmr;
		logic [IRQ_W-1:0] mask;
		logic [IRQ_W-1:0] flags;
		logic [3:0] code;
		logic die;
		logic system_rail;
		logic paused;
		logic [31:0] rd_data;
		bcs_drive_t drive;
	} bcs_top_st_t;

	bcs_top_st_t q, d;

	// ==================================================
	// helpers
	function automatic logic is_fast(input bcs_phase_t ph);
		return (ph == PH_CC) || (ph == PH_CV);
	endfunction

	function automatic logic is_charging(input bcs_phase_t ph);
		return (ph == PH_PQ) || is_fast(ph) || (ph == PH_TO);
	endfunction

	function automatic logic [3:0] code_of(input bcs_phase_t ph, input logic alt);
		logic [3:0] c;
		c = CODE_OFF;
		case (ph)
			PH_OFF: begin
				c = CODE_OFF;
			end
			PH_PQ: begin
				c = CODE_PQ;
			end
			PH_CC: begin
				c = alt ? CODE_CC_ALT : CODE_CC;
			end
			PH_CV: begin
				c = alt ? CODE_CV_ALT : CODE_CV;
			end
			PH_TO: begin
				c = alt ? CODE_TO_ALT : CODE_TO;
			end
			PH_DONE: begin
				c = alt ? CODE_DONE_ALT : CODE_DONE;
			end
			PH_PQ_FAULT: begin
				c = CODE_PQ_FAULT;
			end
			PH_FC_FAULT: begin
				c = CODE_FC_FAULT;
			end
			PH_TEMP_FAULT: begin
				c = CODE_TEMP_FAULT;
			end
			default: begin
				c = CODE_OFF;
			end
		endcase
		return c;
	endfunction

	function automatic logic [TW-1:0] safety_limit(input logic [1:0] sel);
		int unsigned hours;
		hours = SAFETY_BASE_H + SAFETY_STEP_H * (int'(sel) - 1);
		if (sel == 2'h0) begin
			return TMR_MAX;
		end
		return TW'(hours * S_PER_H * MS_PER_S / TICK_PERIOD_MS);
	endfunction

	function automatic logic [TW-1:0] finish_limit(input logic [2:0] sel);
		return TW'(int'(sel) * FINISH_STEP_MIN * S_PER_MIN * MS_PER_S / TICK_PERIOD_MS);
	endfunction

	// ==================================================
	// tick and timers
	logic tick;
	logic restart;
	logic [N_TMR-1:0] t_run;
	logic [N_TMR-1:0] t_clr;
	logic [N_TMR-1:0] t_exp;
	logic [TW-1:0] t_limit [N_TMR];

	bcs_tick #(
		.P_CYCLES(P_TICK_CYCLES)
	) u_tick (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_clear(restart),
		.o_tick(tick)
	);

	genvar gi;
	generate
		for (gi = 0; gi < N_TMR; gi++) begin : g_tmr
			bcs_timer u_timer (
				.i_clock(i_clock),
				.i_arst_n(i_arst_n),
				.i_tick(tick),
				.i_run(t_run[gi]),
				.i_clear(t_clr[gi]),
				.i_limit(t_limit[gi]),
				.o_expired(t_exp[gi])
			);
		end
	endgenerate

	// ==================================================
	// bus decode
	logic wr_ctrl;
	logic wr_flags;
	assign wr_ctrl = i_wr_stb && (i_addr == A_CTRL);
	assign wr_flags = i_wr_stb && (i_addr == A_FLAGS);
	assign restart = wr_ctrl && i_wr_data[CTRL_RESTART_BIT];

	// ==================================================
	// next state
	bcs_ain_t a;
	logic thm;
	logic hotcold;
	logic alt;
	logic start;
	logic pause;
	logic fc_exp;
	bcs_phase_t nxt;
	logic [IRQ_W-1:0] events;
	bcs_status_t st;

	always_comb begin
		a = q.s2;
		thm = q.ctrl.thermistor_enable;
		hotcold = thm && (a.battery_temp_code == ZONE_HOT ||
			a.battery_temp_code == ZONE_COLD);
		alt = thm && (a.battery_temp_code == ZONE_WARM ||
			a.battery_temp_code == ZONE_COOL);
		start = a.below_restart || a.below_prequal;
		fc_exp = t_exp[T_FC] && (q.tmr.safety_timer_sel != 2'h0);
		pause = (q.phase == PH_CC && a.below_fifth) || a.supplement_active;
		nxt = q.phase;
		if (restart || !a.input_valid || !q.ctrl.charge_enable_bit) begin
			nxt = PH_OFF;
		end else if (hotcold && q.phase != PH_OFF && q.phase != PH_TEMP_FAULT) begin
			nxt = PH_TEMP_FAULT;
		end else begin
			case (q.phase)
				PH_OFF: begin
					if (start) begin
						nxt = a.below_prequal ? PH_PQ : PH_CC;
					end
				end
				PH_PQ: begin
					if (t_exp[T_PQ]) begin
						nxt = PH_PQ_FAULT;
					end else if (!a.below_prequal) begin
						nxt = PH_CC;
					end
				end
				PH_CC: begin
					if (fc_exp) begin
						nxt = PH_FC_FAULT;
					end else if (a.below_prequal) begin
						nxt = PH_PQ;
					end else if (a.at_regulation) begin
						nxt = PH_CV;
					end
				end
				PH_CV: begin
					if (fc_exp) begin
						nxt = PH_FC_FAULT;
					end else if (a.below_prequal) begin
						nxt = PH_PQ;
					end else if (a.below_term) begin
						nxt = PH_TO;
					end
				end
				PH_TO: begin
					if (a.below_prequal) begin
						nxt = PH_PQ;
					end else if (t_exp[T_TO]) begin
						nxt = PH_DONE;
					end
				end
				PH_DONE: begin
					if (start) begin
						nxt = a.below_prequal ? PH_PQ : PH_CC;
					end
				end
				PH_PQ_FAULT, PH_FC_FAULT: begin
					nxt = q.phase;
				end
				PH_TEMP_FAULT: begin
					if (!hotcold) begin
						nxt = q.resume;
					end
				end
				default: begin
					nxt = PH_OFF;
				end
			endcase
		end
	end

	// ==================================================
	// timer control
	always_comb begin
		t_limit[T_PQ] = PREQUAL_TICKS;
		t_limit[T_FC] = safety_limit(q.tmr.safety_timer_sel);
		t_limit[T_TO] = finish_limit(q.tmr.finish_timer_sel);
		// temp fault runs nothing; prequal count survives it
		t_run[T_PQ] = (q.phase == PH_PQ);
		t_run[T_FC] = is_fast(q.phase) && !pause;
		t_run[T_TO] = (q.phase == PH_TO);
		t_clr[T_PQ] = restart || (q.phase == PH_OFF) ||
			(nxt == PH_PQ && q.phase != PH_PQ && q.phase != PH_TEMP_FAULT);
		t_clr[T_FC] = restart || (is_fast(nxt) && !is_fast(q.phase));
		t_clr[T_TO] = restart || (nxt == PH_TO && q.phase != PH_TO);
	end

	// ==================================================
	// registers, status and drive
	always_comb begin
		d = q;
		d.s1 = i_analog;
		d.s2 = q.s1;
		d.phase = nxt;
		if (nxt == PH_TEMP_FAULT && q.phase != PH_TEMP_FAULT) begin
			d.resume = q.phase;
		end
		if (wr_ctrl) begin
			d.ctrl = bcs_ctrl_t'(i_wr_data & CTRL_WMASK);
		end
		if (i_wr_stb && i_addr == A_CHG) begin
			d.chg = bcs_chg_t'(i_wr_data & CHG_WMASK);
		end
		if (i_wr_stb && i_addr == A_ALT) begin
			d.alt = bcs_alt_t'(i_wr_data & ALT_WMASK);
		end
		if (i_wr_stb && i_addr == A_TMR) begin
			d.tmr = bcs_tmr_t'(i_wr_data & TMR_WMASK);
		end
		if (i_wr_stb && i_addr == A_MASK) begin
			d.mask = i_wr_data[IRQ_W-1:0];
		end
		d.code = code_of(nxt, alt);
		d.die = a.die_over_limit && is_charging(nxt);
		d.system_rail = a.sys_floor_loop_active;
		d.paused = is_fast(nxt) && pause;
		events = '0;
		events[IRQ_STATE] = (d.code != q.code);
		events[IRQ_DIE] = (d.die != q.die);
		events[IRQ_SYS] = (d.system_rail != q.system_rail);
		// a new event beats a same-cycle clear
		d.flags = q.flags;
		if (wr_flags) begin
			d.flags = q.flags & ~i_wr_data[IRQ_W-1:0];
		end
		d.flags = d.flags | events;
		st = '0;
		st.charge_state_code = q.code;
		st.battery_temp_code = a.battery_temp_code;
		st.die_temp_limiting = q.die;
		st.sys_floor_loop_active = q.system_rail;
		st.safety_timer_paused = q.paused;
		st.input_quality_code = a.input_quality_code;
		d.rd_data = '0;
		if (i_rd_stb) begin
			case (i_addr)
				A_CTRL: begin
					d.rd_data = q.ctrl;
				end
				A_CHG: begin
					d.rd_data = q.chg;
				end
				A_ALT: begin
					d.rd_data = q.alt;
				end
				A_TMR: begin
					d.rd_data = q.tmr;
				end
				A_STATUS: begin
					d.rd_data = st;
				end
				A_FLAGS: begin
					d.rd_data = 32'(q.flags);
				end
				A_MASK: begin
					d.rd_data = 32'(q.mask);
				end
				default: begin
					d.rd_data = '0;
				end
			endcase
		end
		d.drive.charge_on = is_charging(nxt);
		d.drive.battery_node_connect = !a.input_valid || is_charging(nxt);
		d.drive.prequal_mode = (nxt == PH_PQ);
		d.drive.hold_voltage = (nxt == PH_CV) || (nxt == PH_TO);
		d.drive.current_reduce = a.die_over_limit && is_charging(nxt);
		d.drive.current_sel = alt ? q.alt.alt_current_sel : q.chg.fast_current_sel;
		d.drive.voltage_sel = alt ? q.alt.alt_voltage_sel :
			q.chg.regulation_voltage_sel;
		d.drive.prequal_level_sel = q.chg.prequal_level_sel;
		d.drive.prequal_rate_sel = q.chg.prequal_rate_sel;
		d.drive.term_sel = q.chg.term_sel;
		d.drive.die_limit_sel = q.alt.die_limit_sel;
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ==================================================
	// outputs
	assign o_rd_data = q.rd_data;
	assign o_drive = q.drive;
	assign o_irq = |(q.flags & q.mask);
endmodule
`default_nettype wire

/* File: rtl/bcs_pkg.sv */
package bcs_pkg;
	// ==================================================
	// timing
	localparam int unsigned CLOCK_MHZ = 250;
	localparam int unsigned TICK_PERIOD_MS = 1000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_MS * 1000 * CLOCK_MHZ;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned S_PER_MIN = 60;
	localparam int unsigned S_PER_H = 3600;
	localparam int unsigned PREQUAL_MIN = 30;
	localparam int unsigned SAFETY_BASE_H = 3;
	localparam int unsigned SAFETY_STEP_H = 2;
	localparam int unsigned FINISH_STEP_MIN = 5;
	localparam int TW = 15;
	localparam logic [TW-1:0] TMR_MAX = 15'h7fff;
	localparam logic [TW-1:0] PREQUAL_TICKS =
		TW'(PREQUAL_MIN * S_PER_MIN * MS_PER_S / TICK_PERIOD_MS);
	localparam int N_TMR = 3;
	localparam int T_PQ = 0;
	localparam int T_FC = 1;
	localparam int T_TO = 2;
	// ==================================================
	// register map
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CHG = 8'h04;
	localparam logic [7:0] A_ALT = 8'h08;
	localparam logic [7:0] A_TMR = 8'h0c;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_FLAGS = 8'h14;
	localparam logic [7:0] A_MASK = 8'h18;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0003;
	localparam int CTRL_RESTART_BIT = 2;
	localparam logic [31:0] CHG_WMASK = 32'h0337_3f3f;
	localparam logic [31:0] ALT_WMASK = 32'h0007_3f3f;
	localparam logic [31:0] TMR_WMASK = 32'h0000_0073;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam int IRQ_W = 3;
	localparam int IRQ_STATE = 0;
	localparam int IRQ_DIE = 1;
	localparam int IRQ_SYS = 2;
	// ==================================================
	// battery temperature zones
	localparam logic [2:0] ZONE_NORMAL = 3'h0;
	localparam logic [2:0] ZONE_COLD = 3'h1;
	localparam logic [2:0] ZONE_COOL = 3'h2;
	localparam logic [2:0] ZONE_WARM = 3'h3;
	localparam logic [2:0] ZONE_HOT = 3'h4;
	// ==================================================
	// state codes
	localparam logic [3:0] CODE_OFF = 4'h0;
	localparam logic [3:0] CODE_PQ = 4'h1;
	localparam logic [3:0] CODE_CC = 4'h2;
	localparam logic [3:0] CODE_CC_ALT = 4'h3;
	localparam logic [3:0] CODE_CV = 4'h4;
	localparam logic [3:0] CODE_CV_ALT = 4'h5;
	localparam logic [3:0] CODE_TO = 4'h6;
	localparam logic [3:0] CODE_TO_ALT = 4'h7;
	localparam logic [3:0] CODE_DONE = 4'h8;
	localparam logic [3:0] CODE_DONE_ALT = 4'h9;
	localparam logic [3:0] CODE_PQ_FAULT = 4'ha;
	localparam logic [3:0] CODE_FC_FAULT = 4'hb;
	localparam logic [3:0] CODE_TEMP_FAULT = 4'hc;
	typedef enum logic [3:0] {
		PH_OFF, PH_PQ, PH_CC, PH_CV, PH_TO, PH_DONE,
		PH_PQ_FAULT, PH_FC_FAULT, PH_TEMP_FAULT
	} bcs_phase_t;
	// ==================================================
	// carriers
	typedef struct packed {
		logic input_valid;
		logic [1:0] input_quality_code;
		logic below_prequal;
		logic at_regulation;
		logic below_restart;
		logic below_term;
		logic below_fifth;
		logic supplement_active;
		logic die_over_limit;
		logic sys_floor_loop_active;
		logic [2:0] battery_temp_code;
	} bcs_ain_t;
	typedef struct packed {
		logic charge_on;
		logic battery_node_connect;
		logic prequal_mode;
		logic hold_voltage;
		logic current_reduce;
		logic [5:0] current_sel;
		logic [5:0] voltage_sel;
		logic [2:0] prequal_level_sel;
		logic [1:0] prequal_rate_sel;
		logic [1:0] term_sel;
		logic [2:0] die_limit_sel;
	} bcs_drive_t;
	typedef struct packed {
		logic [29:0] rsvd;
		logic thermistor_enable;
		logic charge_enable_bit;
	} bcs_ctrl_t;
	typedef struct packed {
		logic [5:0] r3;
		logic [1:0] term_sel;
		logic [1:0] r2;
		logic [1:0] prequal_rate_sel;
		logic r1b;
		logic [2:0] prequal_level_sel;
		logic [1:0] r1;
		logic [5:0] regulation_voltage_sel;
		logic [1:0] r0;
		logic [5:0] fast_current_sel;
	} bcs_chg_t;
	typedef struct packed {
		logic [12:0] r2;
		logic [2:0] die_limit_sel;
		logic [1:0] r1;
		logic [5:0] alt_voltage_sel;
		logic [1:0] r0;
		logic [5:0] alt_current_sel;
	} bcs_alt_t;
	typedef struct packed {
		logic [24:0] r1;
		logic [2:0] finish_timer_sel;
		logic [1:0] r0;
		logic [1:0] safety_timer_sel;
	} bcs_tmr_t;
	typedef struct packed {
		logic [17:0] r3;
		logic [1:0] input_quality_code;
		logic r2;
		logic safety_timer_paused;
		logic sys_floor_loop_active;
		logic die_temp_limiting;
		logic r1;
		logic [2:0] battery_temp_code;
		logic [3:0] charge_state_code;
	} bcs_status_t;
endpackage

/* File: rtl/bcs_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_tick #(
	parameter int unsigned P_CYCLES = bcs_pkg::TICK_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_clear,
	output logic o_tick
);
	import bcs_pkg::*;
	typedef struct packed {
		logic [27:0] count;
	} bcs_tick_st_t;
	bcs_tick_st_t q, d;
	localparam logic [27:0] LAST = 28'(P_CYCLES - 1);
	always_comb begin
		d = q;
		if (i_clear || q.count == LAST) begin
			d.count = '0;
		end else begin
			d.count = q.count + 28'h1;
		end
	end
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign o_tick = (q.count == LAST) && !i_clear;
endmodule
`default_nettype wire

/* File: rtl/bcs_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_timer (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_tick,
	input wire logic i_run,
	input wire logic i_clear,
	input wire logic [bcs_pkg::TW-1:0] i_limit,
	output logic o_expired
);
	import bcs_pkg::*;
	typedef struct packed {
		logic [TW-1:0] count;
	} bcs_timer_st_t;
	bcs_timer_st_t q, d;
	always_comb begin
		d = q;
		if (i_clear) begin
			d.count = '0;
		end else if (i_run && i_tick && q.count < i_limit) begin
			d.count = q.count + 15'h1;
		end
	end
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign o_expired = (q.count >= i_limit) && !i_clear;
endmodule
`default_nettype wire

/* File: verif/bcs_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_sva (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire logic [31:0] o_rd_data,
	input wire bcs_pkg::bcs_ain_t i_analog,
	input wire bcs_pkg::bcs_drive_t o_drive,
	input wire logic o_irq
);
	import bcs_pkg::*;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	// ==================================================
	// assertions
	chk_invalid_connect: assert property (
		!i_analog.input_valid [*4] |=> o_drive.battery_node_connect && !o_drive.charge_on)
		else $error("battery off system rail with input invalid");
	chk_valid_connect: assert property (
		i_analog.input_valid [*4] ##0 $stable(o_drive.charge_on) [*2]
		|-> o_drive.battery_node_connect == o_drive.charge_on)
		else $error("battery connected while not charging");
	chk_die_reduce: assert property (
		i_analog.die_over_limit [*4] ##0 $stable(o_drive.charge_on) [*2]
		|-> o_drive.current_reduce == o_drive.charge_on)
		else $error("current not reduced on die over limit");
	chk_die_release: assert property (
		!i_analog.die_over_limit [*4] |=> !o_drive.current_reduce)
		else $error("current reduced without die over limit");
	chk_pq_forced: assert property (
		i_analog.below_prequal [*4] ##0 o_drive.charge_on [*2] |-> ##[0:1] o_drive.prequal_mode)
		else $error("charging above prequal rate on low battery");
	chk_pq_left: assert property (
		!i_analog.below_prequal [*4] |-> ##[1:2] !o_drive.prequal_mode)
		else $error("prequal kept above threshold");
	chk_hold_charging: assert property (
		o_drive.hold_voltage |-> o_drive.charge_on && !o_drive.prequal_mode)
		else $error("voltage hold outside fast charge or top-off");
	chk_rd_idle: assert property (
		!i_rd_stb |=> o_rd_data == 32'h0)
		else $error("read data outside read cycle");
	cov_prequal: cover property (o_drive.prequal_mode);
	cov_finish: cover property (o_drive.hold_voltage ##1 !o_drive.charge_on);
	cov_reduce: cover property ($rose(o_drive.current_reduce));
	cov_irq: cover property ($rose(o_irq));
endmodule
`default_nettype wire

/* File: verif/bcs_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_analog_model #(
	parameter int PQ_MV = 3000,
	parameter int REG_MV = 4200,
	parameter int RESTART_MV = 150,
	parameter int TERM_PCT = 10
) (
	input wire logic i_clock,
	input wire logic i_valid,
	input wire logic [15:0] i_mv,
	input wire logic [7:0] i_pct,
	input wire logic [2:0] i_zone,
	input wire logic i_die,
	input wire logic i_sys,
	input wire logic i_supp,
	output var bcs_pkg::bcs_ain_t o_analog
);
	import bcs_pkg::*;
	initial o_analog = '0;
	// comparators settle one clock after the battery changes
	always @(posedge i_clock) begin
		o_analog.input_valid <= i_valid;
		o_analog.input_quality_code <= {i_valid, 1'b0};
		o_analog.below_prequal <= i_mv < PQ_MV;
		o_analog.at_regulation <= i_mv >= REG_MV;
		o_analog.below_restart <= i_mv < REG_MV - RESTART_MV;
		o_analog.below_term <= i_pct < TERM_PCT;
		o_analog.below_fifth <= i_pct < 20;
		o_analog.supplement_active <= i_supp;
		o_analog.die_over_limit <= i_die;
		o_analog.sys_floor_loop_active <= i_sys;
		o_analog.battery_temp_code <= i_zone;
	end
endmodule
`default_nettype wire

/* File: verif/test_battery_charge_state_machine.sv */
`timescale 1ns/1ps
`default_nettype none
module test_battery_charge_state_machine;
	import bcs_pkg::*;
	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_wr_stb = 1'b0;
	logic i_rd_stb = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wr_data = 32'h0;
	logic [31:0] o_rd_data, rd_q, rnd, cfg_chg, cfg_alt;
	logic o_irq;
	logic valid = 1'b0, die = 1'b0, system_rail = 1'b0, supp = 1'b0;
	logic [2:0] zone = 3'h0;
	logic [15:0] mv = 16'h0af0;
	logic [7:0] pct = 8'h64;
	bcs_ain_t ain;
	bcs_drive_t drv;
	int miscompares = 0, n_compared = 0, seed = 32'hab2f;
	longint t0;
	logic [7:0] ra[5] = '{A_CTRL, A_CHG, A_ALT, A_TMR, A_MASK};
	logic [31:0] rm[5] = '{CTRL_WMASK, CHG_WMASK, ALT_WMASK, TMR_WMASK, 32'h0000_0007};
	logic [2:0] jz[2] = '{ZONE_WARM, ZONE_COOL};
	bcs_top #(.P_TICK_CYCLES(1)) bcs_top_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
		.i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
		.o_rd_data(o_rd_data), .i_analog(ain), .o_drive(drv), .o_irq(o_irq));
	bcs_analog_model bcs_analog_model_i (.i_clock(i_clock), .i_valid(valid), .i_mv(mv),
		.i_pct(pct), .i_zone(zone), .i_die(die), .i_sys(system_rail), .i_supp(supp), .o_analog(ain));
	initial forever #2 i_clock = ~i_clock;
	// ==================================================
	// checks and bus cycles
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_span(input string what, input int exp);
		int got;
		got = int'(($time - t0) / 4);
		n_compared++;
		if (got < exp - 4 || got > exp + 24) begin
			miscompares++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_wr_stb <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_clock);
		i_wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clock);
		i_rd_stb <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd_stb <= 1'b0;
		#1 rd_q = o_rd_data;
	endtask
	task automatic wait_code(input logic [3:0] code, input int limit);
		int n;
		n = 0;
		do begin
			rd(A_STATUS);
			n += 2;
		end while (rd_q[3:0] !== code && n < limit);
		check("state code", {28'h0, code}, {28'h0, rd_q[3:0]});
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#(60000 * 4);
		miscompares++;
		$display("[ERR] run end expected done seen timeout");
		give_verdict();
	end
	// ==================================================
	// scenarios
	initial begin
		repeat (8) @(posedge i_clock);
		i_arst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(ra[i]);
			check("reset value", REG_RESET, rd_q);
			rnd = $random(seed);
			wr(ra[i], rnd);
			rd(ra[i]);
			check("read back", rnd & rm[i], rd_q);
		end
		wr(8'h1c, 32'hffff_ffff);
		wr(A_STATUS, 32'hffff_ffff);
		rd(8'h1c);
		check("unmapped", 32'h0, rd_q);
		rd(A_STATUS);
		check("status idle", 32'h0, rd_q);
		cfg_chg = $random(seed) & CHG_WMASK;
		cfg_alt = $random(seed) & ALT_WMASK;
		wr(A_CHG, cfg_chg);
		wr(A_ALT, cfg_alt);
		wr(A_TMR, 32'h0000_0011);
		wr(A_MASK, 32'h0000_0007);
		wr(A_CTRL, 32'h0000_0003);
		wr(A_FLAGS, 32'h0000_0007);
		@(posedge i_clock) valid <= 1'b1;
		wait_code(CODE_PQ, 40);
		check("pq drive", 32'h7, {29'h0, drv.charge_on, drv.battery_node_connect, drv.prequal_mode});
		check("pq level", {25'h0, cfg_chg[18:16], cfg_chg[21:20], cfg_chg[25:24]},
			{25'h0, drv.prequal_level_sel, drv.prequal_rate_sel, drv.term_sel});
		check("input quality", 32'h2000, rd_q & 32'h3000);
		check("irq on", 32'h1, {31'h0, o_irq});
		wr(A_MASK, 32'h0000_0006);
		#1 check("irq masked", 32'h0, {31'h0, o_irq});
		wr(A_FLAGS, 32'h0000_0007);
		wr(A_MASK, 32'h0000_0007);
		#1 check("irq cleared", 32'h0, {31'h0, o_irq});
		@(posedge i_clock) mv <= 16'd3800;
		wait_code(CODE_CC, 40);
		check("cc sel", {20'h0, cfg_chg[13:8], cfg_chg[5:0]},
			{20'h0, drv.voltage_sel, drv.current_sel});
		foreach (jz[i]) begin
			@(posedge i_clock) zone <= jz[i];
			// zone reaches the status field three edges later
			repeat (4) @(posedge i_clock);
			wait_code(CODE_CC_ALT, 40);
			check("alt sel", {20'h0, cfg_alt[13:8], cfg_alt[5:0]},
				{20'h0, drv.voltage_sel, drv.current_sel});
			check("die limit", {29'h0, cfg_alt[18:16]}, {29'h0, drv.die_limit_sel});
			check("zone", {29'h0, jz[i]}, {29'h0, rd_q[6:4]});
		end
		@(posedge i_clock) zone <= ZONE_NORMAL;
		wait_code(CODE_CC, 40);
		wr(A_FLAGS, 32'h0000_0007);
		for (int i = 0; i < 2; i++) begin
			@(posedge i_clock) begin
				die <= ~die;
				system_rail <= ~system_rail;
			end
			repeat (8) @(posedge i_clock);
			rd(A_STATUS);
			check("die loop status", {22'h0, ~i[0], ~i[0], 8'h0}, rd_q & 32'h300);
			check("reduce", {31'h0, ~i[0]}, {31'h0, drv.current_reduce});
			rd(A_FLAGS);
			check("die loop flags", 32'h6, rd_q);
			wr(A_FLAGS, 32'h0000_0007);
		end
		@(posedge i_clock) mv <= 16'd4200;
		wait_code(CODE_CV, 40);
		check("hold", 32'h1, {31'h0, drv.hold_voltage});
		@(posedge i_clock) pct <= 8'd5;
		wait_code(CODE_TO, 40);
		repeat (200) @(posedge i_clock);
		@(posedge i_clock) zone <= ZONE_HOT;
		wait_code(CODE_TEMP_FAULT, 40);
		check("temp fault drive", 32'h0, {30'h0, drv.charge_on, drv.battery_node_connect});
		repeat (100) @(posedge i_clock);
		@(posedge i_clock) zone <= ZONE_NORMAL;
		t0 = $time;
		wait_code(CODE_TO, 40);
		wait_code(CODE_DONE, 400);
		check_span("top-off time", 300);
		check("done drive", 32'h0, {30'h0, drv.charge_on, drv.battery_node_connect});
		@(posedge i_clock) begin
			mv <= 16'd3800;
			pct <= 8'd100;
		end
		t0 = $time;
		wait_code(CODE_CC, 40);
		repeat (3000) @(posedge i_clock);
		@(posedge i_clock) pct <= 8'd15;
		repeat (20) @(posedge i_clock);
		rd(A_STATUS);
		check("paused", 32'h400, rd_q & 32'h400);
		repeat (476) @(posedge i_clock);
		@(posedge i_clock) begin
			pct <= 8'd100;
			supp <= 1'b1;
		end
		repeat (499) @(posedge i_clock);
		@(posedge i_clock) supp <= 1'b0;
		wait_code(CODE_FC_FAULT, 12000);
		check_span("safety time", 11800);
		check("fc fault drive", 32'h0, {30'h0, drv.charge_on, drv.battery_node_connect});
		@(posedge i_clock) mv <= 16'd2800;
		repeat (50) @(posedge i_clock);
		wait_code(CODE_FC_FAULT, 4);
		wr(A_CTRL, 32'h0000_0002);
		wr(A_CTRL, 32'h0000_0003);
		t0 = $time;
		wait_code(CODE_PQ, 40);
		wait_code(CODE_PQ_FAULT, 2000);
		check_span("prequal time", 1800);
		@(posedge i_clock) valid <= 1'b0;
		wait_code(CODE_OFF, 40);
		check("invalid drive", 32'h1, {30'h0, drv.charge_on, drv.battery_node_connect});
		@(posedge i_clock) begin
			valid <= 1'b1;
			mv <= 16'd4100;
		end
		repeat (20) @(posedge i_clock);
		wait_code(CODE_OFF, 4);
		check("fresh drive", 32'h0, {30'h0, drv.charge_on, drv.battery_node_connect});
		@(posedge i_clock) mv <= 16'd4000;
		wait_code(CODE_CC, 40);
		// zero top-off length ends charging right after termination
		wr(A_TMR, 32'h0000_0000);
		@(posedge i_clock) begin
			mv <= 16'd4200;
			pct <= 8'd5;
		end
		wait_code(CODE_DONE, 40);
		wr(A_FLAGS, 32'h0000_0007);
		wr(A_CTRL, 32'h0000_0007);
		repeat (10) @(posedge i_clock);
		rd(A_FLAGS);
		check("restart flag", 32'h1, rd_q & 32'h1);
		wait_code(CODE_OFF, 4);
		give_verdict();
	end
endmodule
bind bcs_top bcs_sva bcs_sva_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr),
	.i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
	.i_analog(i_analog), .o_drive(o_drive), .o_irq(o_irq));
`default_nettype wire
